// >>> core/gpp_consts.vh
// Constants for the general purpose parallel port: register byte offsets,
// pin counts, reset values and bus response codes.
// Assumes inclusion by bare name from the port's design files.
`ifndef GPP_CONSTS_VH
`define GPP_CONSTS_VH

// Pin group sizes
`define GPP_N_IN 12
`define GPP_N_OUT 24
`define GPP_N_IO 6
`define GPP_N_EXT 13
// Bidirectional bits seen by software: dedicated pins then spare memory pins
`define GPP_N_BIDIR 19
// Interrupt sources: input-only, bidirectional, spare memory pins
`define GPP_N_IRQ 31

// Register byte offsets on the AXI4-Lite slave
`define GPP_OFS_IN_LEVEL 8'h00
`define GPP_OFS_OUT_SET 8'h04
`define GPP_OFS_OUT_CLR 8'h08
`define GPP_OFS_OUT_STATE 8'h0C
`define GPP_OFS_IO_DIR 8'h10
`define GPP_OFS_IO_SET 8'h14
`define GPP_OFS_IO_CLR 8'h18
`define GPP_OFS_IO_STATE 8'h1C
`define GPP_OFS_IO_LEVEL 8'h20
`define GPP_OFS_FUNC_SEL 8'h24
`define GPP_OFS_STATUS 8'h28

// Reset values
`define GPP_RST_OUT_STATE 24'h00_0000
`define GPP_RST_IO_DIR 19'h0_0000
`define GPP_RST_IO_STATE 19'h0_0000
`define GPP_RST_FUNC_SEL 24'h00_0000

// Status register field
`define GPP_STAT_HALF_BIT 0

// AXI response codes
`define GPP_RESP_OKAY 2'h0
`define GPP_RESP_SLVERR 2'h2

`endif

// >>> core/gpp_sync.v
// Two-stage synchroniser, one per bit, for pin levels entering the clock domain.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/1ns
module gpp_sync #(
   parameter WIDTH = 31
) (
   input wire CLOCK,
   input wire SYS_RST,
   input wire [WIDTH-1:0] D_ASYNC,
   output wire [WIDTH-1:0] Q_SYNC
);
   genvar gi;
   // First stage feeds only the second stage
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
         reg meta_ff;
         reg sync_ff;
         always @(posedge CLOCK) begin
            if (SYS_RST) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else begin
               meta_ff <= D_ASYNC[gi];
               sync_ff <= meta_ff;
            end
         end
         assign Q_SYNC[gi] = sync_ff;
      end
   endgenerate
endmodule // gpp_sync

// >>> core/gpp_port.v
// General purpose parallel port: input-only, output-only and bidirectional
// pins, plus spare memory data pins reused when the memory bus is half width.
// Assumes an AXI4-Lite master on CLOCK, a memory controller on the same clock
// and an interrupt controller that takes the raw level sources.
// Software sees eleven word registers; set and clear registers read as zero.
// A write outside the map answers with an error and changes nothing.
// Pin levels arrive unsynchronised and pass two flops before any use.
//
// Behaviour
// R1 - Twelve input-only, twenty-four output-only and six bidirectional pins.
// R2 - One direction register, one bit per bidirectional pin.
// R3 - Direction may be rewritten any time and takes effect at once; here the pin enable moves one edge after the direction register.
// R4 - Set and clear registers change many output bits in one write.
// R5 - Stored output values read back for output-only and bidirectional pins.
// R6 - Bidirectional pins also show their sampled real level.
// R7 - Output pins selectable between peripheral function and general use.
// R8 - Half width memory bus frees thirteen data pins as bidirectional pins.
// R9 - Bidirectional and input-only pins feed the interrupt controller directly.
// R10 - Zero bits in set or clear writes leave outputs unchanged.
// R11 - Bidirectional pins come out of reset as inputs.
`timescale 1ns/1ns
`include "gpp_consts.vh"
module gpp_port (
   input wire CLOCK,
   input wire SYS_RST,
   // AXI4-Lite slave
   input wire [7:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output wire [1:0] S_AXI_BRESP,
   output wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [7:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0] S_AXI_RRESP,
   output wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // Dedicated pins
   input wire [`GPP_N_IN-1:0] INPUT_ONLY_PIN_I,
   output wire [`GPP_N_OUT-1:0] OUTPUT_ONLY_PIN_O,
   input wire [`GPP_N_OUT-1:0] PERIPH_OUT,
   input wire [`GPP_N_IO-1:0] IO_PIN_I,
   output wire [`GPP_N_IO-1:0] IO_PIN_O,
   output wire [`GPP_N_IO-1:0] IO_PIN_OE_N,
   // Spare memory data pins and the memory controller's own drive of them
   input wire MEM_HALF_WIDTH,
   input wire [`GPP_N_EXT-1:0] MEMC_DATA_O,
   input wire [`GPP_N_EXT-1:0] MEMC_DATA_OE_N,
   input wire [`GPP_N_EXT-1:0] MEM_PIN_I,
   output wire [`GPP_N_EXT-1:0] MEM_PIN_O,
   output wire [`GPP_N_EXT-1:0] MEM_PIN_OE_N,
   output wire [`GPP_N_EXT-1:0] MEMC_DATA_I,
   // Raw interrupt sources
   output wire [`GPP_N_IRQ-1:0] IRQ_SRC
);
   // Bus handshake state
   reg awready_ff, nxt_awready;
   reg wready_ff, nxt_wready;
   reg aw_got_ff, nxt_aw_got;
   reg w_got_ff, nxt_w_got;
   reg bvalid_ff, nxt_bvalid;
   reg [1:0] bresp_ff, nxt_bresp;
   reg [7:0] aw_addr_ff, nxt_aw_addr;
   reg [31:0] w_data_ff, nxt_w_data;
   reg [3:0] w_strb_ff, nxt_w_strb;
   reg arready_ff, nxt_arready;
   reg rvalid_ff, nxt_rvalid;
   reg [31:0] rdata_ff, nxt_rdata;
   reg [1:0] rresp_ff, nxt_rresp;
   // Port state
   reg [`GPP_N_OUT-1:0] out_state_ff, nxt_out_state;
   reg [`GPP_N_BIDIR-1:0] io_dir_ff, nxt_io_dir;
   reg [`GPP_N_BIDIR-1:0] io_state_ff, nxt_io_state;
   reg [`GPP_N_OUT-1:0] func_sel_ff, nxt_func_sel;
   // Pin drivers
   reg [`GPP_N_OUT-1:0] out_pin_ff;
   reg [`GPP_N_IO-1:0] io_o_ff, io_oe_n_ff;
   reg [`GPP_N_EXT-1:0] mem_o_ff, mem_oe_n_ff, memc_i_ff;
   reg [`GPP_N_IRQ-1:0] irq_ff;

   // Synced pin levels, split into their three groups
   wire [`GPP_N_IRQ-1:0] pin_sync;
   wire [`GPP_N_IN-1:0] in_lvl;
   wire [`GPP_N_IO-1:0] io_lvl;
   wire [`GPP_N_EXT-1:0] ext_lvl;
   wire [`GPP_N_BIDIR-1:0] bidir_lvl;
   // Bus decode terms
   wire aw_take, w_take, ar_take, do_write;
   wire [31:0] wmask, wd;
   reg wr_hit, rd_hit;
   reg [31:0] rd_word;

   // All pin levels pass two flops before anything reads them
   gpp_sync #(.WIDTH(`GPP_N_IRQ)) u_sync (
      .CLOCK(CLOCK),
      .SYS_RST(SYS_RST),
      .D_ASYNC({MEM_PIN_I, IO_PIN_I, INPUT_ONLY_PIN_I}),
      .Q_SYNC(pin_sync)
   );
   assign in_lvl = pin_sync[`GPP_N_IN-1:0];
   assign io_lvl = pin_sync[`GPP_N_IN+`GPP_N_IO-1:`GPP_N_IN];
   assign ext_lvl = pin_sync[`GPP_N_IRQ-1:`GPP_N_IN+`GPP_N_IO];
   assign bidir_lvl = {ext_lvl, io_lvl}; // see R6

   // Handshake terms
   assign aw_take = S_AXI_AWVALID & awready_ff;
   assign w_take = S_AXI_WVALID & wready_ff;
   assign ar_take = S_AXI_ARVALID & arready_ff;
   assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;
   // Byte strobes widened to a bit mask
   assign wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}},
                   {8{w_strb_ff[0]}}};
   // Unstrobed lanes count as zero bits, so they never touch an output
   assign wd = w_data_ff & wmask;

   // Write channel: address and data taken in either order, then one response
   always @* begin
      // Each half is held until both have arrived
      nxt_aw_got = (aw_got_ff | aw_take) & ~do_write;
      nxt_w_got = (w_got_ff | w_take) & ~do_write;
      nxt_aw_addr = aw_take ? S_AXI_AWADDR : aw_addr_ff;
      nxt_w_data = w_take ? S_AXI_WDATA : w_data_ff;
      nxt_w_strb = w_take ? S_AXI_WSTRB : w_strb_ff;
      nxt_bvalid = do_write | (bvalid_ff & ~S_AXI_BREADY);
      nxt_bresp = do_write ? (wr_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR) : bresp_ff;
      // Readies stay low until the response is taken: one write at a time
      nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
      nxt_wready = ~nxt_w_got & ~nxt_bvalid;
   end

   // Register writes
   always @* begin
      nxt_out_state = out_state_ff;
      nxt_io_dir = io_dir_ff;
      nxt_io_state = io_state_ff;
      nxt_func_sel = func_sel_ff;
      wr_hit = 1'b1;
      // The held address selects; do_write lasts one cycle, so one update per write
      case (aw_addr_ff)
         `GPP_OFS_OUT_SET: begin
            if (do_write) nxt_out_state = out_state_ff | wd[`GPP_N_OUT-1:0]; // see R4 see R10
         end
         `GPP_OFS_OUT_CLR: begin
            if (do_write) nxt_out_state = out_state_ff & ~wd[`GPP_N_OUT-1:0]; // see R4 see R10
         end
         `GPP_OFS_IO_DIR: begin
            // Byte lanes merge so a partial write keeps the other bits
            if (do_write) nxt_io_dir = (io_dir_ff & ~wmask[`GPP_N_BIDIR-1:0]) |
                                       wd[`GPP_N_BIDIR-1:0]; // see R2 see R3
         end
         `GPP_OFS_IO_SET: begin
            if (do_write) nxt_io_state = io_state_ff | wd[`GPP_N_BIDIR-1:0]; // see R4 see R10
         end
         `GPP_OFS_IO_CLR: begin
            if (do_write) nxt_io_state = io_state_ff & ~wd[`GPP_N_BIDIR-1:0]; // see R4 see R10
         end
         `GPP_OFS_FUNC_SEL: begin
            if (do_write) nxt_func_sel = (func_sel_ff & ~wmask[`GPP_N_OUT-1:0]) |
                                         wd[`GPP_N_OUT-1:0]; // see R7
         end
         // Read-only registers accept the write and ignore it
         `GPP_OFS_IN_LEVEL, `GPP_OFS_OUT_STATE, `GPP_OFS_IO_STATE,
         `GPP_OFS_IO_LEVEL, `GPP_OFS_STATUS: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   // Read decode; unused upper bits read as zero
   always @* begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      // Decoded straight from the bus; only used in the cycle of the take
      case (S_AXI_ARADDR)
         `GPP_OFS_IN_LEVEL: rd_word[`GPP_N_IN-1:0] = in_lvl;
         `GPP_OFS_OUT_SET, `GPP_OFS_OUT_CLR, `GPP_OFS_IO_SET, `GPP_OFS_IO_CLR: begin
            rd_word = 32'h0000_0000;
         end
         `GPP_OFS_OUT_STATE: rd_word[`GPP_N_OUT-1:0] = out_state_ff; // see R5
         `GPP_OFS_IO_DIR: rd_word[`GPP_N_BIDIR-1:0] = io_dir_ff;
         `GPP_OFS_IO_STATE: rd_word[`GPP_N_BIDIR-1:0] = io_state_ff; // see R5
         `GPP_OFS_IO_LEVEL: rd_word[`GPP_N_BIDIR-1:0] = bidir_lvl; // see R6
         `GPP_OFS_FUNC_SEL: rd_word[`GPP_N_OUT-1:0] = func_sel_ff;
         `GPP_OFS_STATUS: rd_word[`GPP_STAT_HALF_BIT] = MEM_HALF_WIDTH;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read channel: one read at a time, data one cycle after the address
   always @* begin
      nxt_rvalid = ar_take | (rvalid_ff & ~S_AXI_RREADY);
      nxt_rdata = ar_take ? rd_word : rdata_ff;
      nxt_rresp = ar_take ? (rd_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR) : rresp_ff;
      // Data held until taken, and no new address accepted meanwhile
      nxt_arready = ~nxt_rvalid;
   end

   // Bus flops; ready lines stay low during reset and rise one edge later
   // Stored address and data are cleared too, so a stale write cannot replay
   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `GPP_RESP_OKAY;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `GPP_RESP_OKAY;
      end else begin
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         aw_addr_ff <= nxt_aw_addr;
         w_data_ff <= nxt_w_data;
         w_strb_ff <= nxt_w_strb;
         arready_ff <= nxt_arready;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   // Port registers; directions start as inputs so no bidirectional pin drives the board
   // Output values survive direction changes, so a turned pin keeps its level
   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         out_state_ff <= `GPP_RST_OUT_STATE;
         io_dir_ff <= `GPP_RST_IO_DIR; // see R11
         io_state_ff <= `GPP_RST_IO_STATE;
         func_sel_ff <= `GPP_RST_FUNC_SEL;
      end else begin
         out_state_ff <= nxt_out_state;
         io_dir_ff <= nxt_io_dir;
         io_state_ff <= nxt_io_state;
         func_sel_ff <= nxt_func_sel;
      end
   end

   // Pin drivers, registered so each pin moves one edge after its register.
   // The memory controller's drive of the spare pins gains the same one-cycle
   // delay; traded for clean flop outputs on every pin.
   always @(posedge CLOCK) begin
      if (SYS_RST) begin
         out_pin_ff <= {`GPP_N_OUT{1'b0}};
         io_o_ff <= {`GPP_N_IO{1'b0}};
         io_oe_n_ff <= {`GPP_N_IO{1'b1}}; // see R11
         mem_o_ff <= {`GPP_N_EXT{1'b0}};
         mem_oe_n_ff <= {`GPP_N_EXT{1'b1}};
         memc_i_ff <= {`GPP_N_EXT{1'b0}};
         irq_ff <= {`GPP_N_IRQ{1'b0}};
      end else begin
         // Each output pin takes either the peripheral drive or its stored bit
         out_pin_ff <= (func_sel_ff & PERIPH_OUT) | (~func_sel_ff & out_state_ff); // see R1 see R7
         io_o_ff <= io_state_ff[`GPP_N_IO-1:0];
         io_oe_n_ff <= ~io_dir_ff[`GPP_N_IO-1:0]; // see R3
         // Spare pins belong to the memory controller unless the bus is half width
         if (MEM_HALF_WIDTH) begin
            mem_o_ff <= io_state_ff[`GPP_N_BIDIR-1:`GPP_N_IO]; // see R8
            mem_oe_n_ff <= ~io_dir_ff[`GPP_N_BIDIR-1:`GPP_N_IO]; // see R8
         end else begin
            mem_o_ff <= MEMC_DATA_O;
            mem_oe_n_ff <= MEMC_DATA_OE_N;
         end
         // Synced levels reach the memory controller as well
         memc_i_ff <= ext_lvl;
         // Spare pins raise interrupts only while they serve as port pins
         irq_ff <= {ext_lvl & {`GPP_N_EXT{MEM_HALF_WIDTH}}, io_lvl, in_lvl}; // see R9
      end
   end

   // Every output is a flop: no logic between register and pin
   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY = wready_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;
   assign OUTPUT_ONLY_PIN_O = out_pin_ff;
   assign IO_PIN_O = io_o_ff;
   assign IO_PIN_OE_N = io_oe_n_ff;
   assign MEM_PIN_O = mem_o_ff;
   assign MEM_PIN_OE_N = mem_oe_n_ff;
   assign MEMC_DATA_I = memc_i_ff;
   assign IRQ_SRC = irq_ff;
endmodule // gpp_port

// >>> testbench/gpp_port_properties.sv
// Checker for the parallel port: bus answers, pin drive and interrupt sources.
// Assumes the master offers write address and data together.
`timescale 1ns/1ns
module gpp_port_chk (
   input wire CLOCK,
   input wire SYS_RST,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire S_AXI_BVALID,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire S_AXI_RVALID,
   input wire [11:0] INPUT_ONLY_PIN_I,
   input wire [23:0] OUTPUT_ONLY_PIN_O,
   input wire [23:0] PERIPH_OUT,
   input wire [5:0] IO_PIN_I,
   input wire [5:0] IO_PIN_OE_N,
   input wire MEM_HALF_WIDTH,
   input wire [12:0] MEMC_DATA_O,
   input wire [12:0] MEMC_DATA_OE_N,
   input wire [12:0] MEM_PIN_O,
   input wire [12:0] MEM_PIN_OE_N,
   input wire [30:0] IRQ_SRC
);
   // Cycles since reset; synchronisers hold stale zeros until it saturates
   reg [2:0] up_ff;
   wire [2:0] nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
   wire warm = (up_ff == 3'h7);
   wire wr_hs = S_AXI_AWVALID & S_AXI_AWREADY & S_AXI_WVALID & S_AXI_WREADY;
   always @(posedge CLOCK) begin
      if (SYS_RST) up_ff <= 3'h0;
      else up_ff <= nxt_up;
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   // Write answer: one quiet cycle, then the response
   sequence s_b_resp;
      !S_AXI_BVALID ##1 S_AXI_BVALID;
   endsequence
   sequence s_in_quiet;
      (warm && $stable(INPUT_ONLY_PIN_I)) [*4];
   endsequence
   chk_reset_idle: assert property ($fell(SYS_RST) |-> &IO_PIN_OE_N && IRQ_SRC == 31'h0)
      else $error("pins not idle after reset");
   chk_wr_answer: assert property (wr_hs |=> s_b_resp)
      else $error("write response missing");
   chk_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data missing");
   chk_dir_cause: assert property ($changed(IO_PIN_OE_N) |-> $past(wr_hs, 3))
      else $error("direction moved without a write");
   chk_out_cause: assert property ($changed(OUTPUT_ONLY_PIN_O) |->
      $past(wr_hs, 3) || $past(PERIPH_OUT) != $past(PERIPH_OUT, 2))
      else $error("output moved without cause");
   chk_mem_follow: assert property (!MEM_HALF_WIDTH [*2] |=>
      MEM_PIN_OE_N == $past(MEMC_DATA_OE_N) && MEM_PIN_O == $past(MEMC_DATA_O))
      else $error("spare pins not with memory");
   chk_irq_input: assert property (s_in_quiet |-> IRQ_SRC[11:0] == INPUT_ONLY_PIN_I)
      else $error("input source wrong");
   chk_irq_bidir: assert property ((warm && $stable(IO_PIN_I)) [*4] |->
      IRQ_SRC[17:12] == IO_PIN_I)
      else $error("bidir source wrong");
   chk_irq_spare: assert property (!MEM_HALF_WIDTH [*4] |-> IRQ_SRC[30:18] == 13'h0000)
      else $error("spare source not quiet");
endmodule // gpp_port_chk

bind gpp_port gpp_port_chk u_gpp_port_chk (
   .CLOCK(CLOCK), .SYS_RST(SYS_RST), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
   .INPUT_ONLY_PIN_I(INPUT_ONLY_PIN_I), .OUTPUT_ONLY_PIN_O(OUTPUT_ONLY_PIN_O),
   .PERIPH_OUT(PERIPH_OUT), .IO_PIN_I(IO_PIN_I), .IO_PIN_OE_N(IO_PIN_OE_N),
   .MEM_HALF_WIDTH(MEM_HALF_WIDTH), .MEMC_DATA_O(MEMC_DATA_O),
   .MEMC_DATA_OE_N(MEMC_DATA_OE_N), .MEM_PIN_O(MEM_PIN_O), .MEM_PIN_OE_N(MEM_PIN_OE_N),
   .IRQ_SRC(IRQ_SRC)
);

// >>> testbench/gpp_board.sv
// Board side of the port: a driver on every input-only, bidirectional and spare memory pin.
// Assumes the board yields a bidirectional line whenever the port drives it.
`timescale 1ns/1ns
module gpp_board (
   input wire [11:0] in_lvl,
   input wire [5:0] io_lvl,
   input wire [12:0] mem_lvl,
   input wire [5:0] io_o,
   input wire [5:0] io_oe_n,
   input wire [12:0] mem_o,
   input wire [12:0] mem_oe_n,
   output wire [11:0] in_pin,
   output wire [5:0] io_i,
   output wire [12:0] mem_i
);
   // Wire level: the port where it drives, else the board's own driver
   assign in_pin = in_lvl;
   assign io_i = (io_o & ~io_oe_n) | (io_lvl & io_oe_n);
   assign mem_i = (mem_o & ~mem_oe_n) | (mem_lvl & mem_oe_n);
endmodule // gpp_board

// >>> testbench/tb_gpp_port.sv
// Self-checking bench for the parallel port.
// Assumes the bound checker and the board model beside the port.
`timescale 1ns/1ns
`include "gpp_consts.vh"
module tb_gpp_port;
   reg clock = 1'b0;
   reg sys_rst = 1'b1;
   reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, half = 1'b0;
   reg [7:0] awaddr = 8'h00, araddr = 8'h00;
   reg [31:0] wdata = 32'h0000_0000;
   reg [3:0] wstrb = 4'h0;
   reg [23:0] periph = 24'h00_0000;
   reg [12:0] memc_o = 13'h0000, memc_oe_n = 13'h1FFF, mem_lvl = 13'h0000;
   reg [11:0] in_lvl = 12'h000;
   reg [5:0] io_lvl = 6'h00;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [23:0] out_pin;
   wire [5:0] io_o, io_oe_n, io_i;
   wire [12:0] mem_o, mem_oe_n, mem_i, memc_i;
   wire [11:0] in_pin;
   wire [30:0] irq;
   integer failures = 0, cmp_count = 0, seed = 32'h7c0b_ac5b, i;
   reg [31:0] r, lv;
   reg [23:0] exp_out, m;
   reg [33:0] exp_r[$];
   reg [1:0] exp_b[$];
   gpp_port u_gpp_port (
      .CLOCK(clock), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .INPUT_ONLY_PIN_I(in_pin), .OUTPUT_ONLY_PIN_O(out_pin), .PERIPH_OUT(periph),
      .IO_PIN_I(io_i), .IO_PIN_O(io_o), .IO_PIN_OE_N(io_oe_n), .MEM_HALF_WIDTH(half),
      .MEMC_DATA_O(memc_o), .MEMC_DATA_OE_N(memc_oe_n), .MEM_PIN_I(mem_i), .MEM_PIN_O(mem_o),
      .MEM_PIN_OE_N(mem_oe_n), .MEMC_DATA_I(memc_i), .IRQ_SRC(irq));
   gpp_board u_gpp_board (
      .in_lvl(in_lvl), .io_lvl(io_lvl), .mem_lvl(mem_lvl), .io_o(io_o), .io_oe_n(io_oe_n),
      .mem_o(mem_o), .mem_oe_n(mem_oe_n), .in_pin(in_pin), .io_i(io_i), .mem_i(mem_i));
   initial forever #50 clock = ~clock;
   task check(input string nm, input [33:0] seen, input [33:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Address and data go out together; each drops once taken
   task wr(input [7:0] a, input [31:0] d, input [1:0] er = `GPP_RESP_OKAY, input [3:0] s = 4'hF);
      exp_b.push_back(er);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask
   task rd(input [7:0] a, input [31:0] d, input [1:0] er = `GPP_RESP_OKAY);
      exp_r.push_back({er, d});
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask
   task done(input string n);
      $display("test %s finished", n);
   endtask
   task report_and_stop;
      failures = failures + exp_r.size() + exp_b.size();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Scoreboard: each answer is matched to the oldest note
   always @(posedge clock) begin
      if (rvalid && rready) check("read", {rresp, rdata}, exp_r.pop_front());
      if (bvalid && bready) check("bresp", {32'h0000_0000, bresp}, exp_b.pop_front());
   end
   initial begin
      repeat (16) @(posedge clock);
      lv = $random(seed);
      sys_rst <= 1'b0;
      in_lvl <= lv[11:0];
      io_lvl <= lv[17:12];
      mem_lvl <= lv[30:18];
      repeat (8) @(posedge clock);
      check("io_oe_n", io_oe_n, 6'h3F);
      check("irq", irq, {13'h0000, lv[17:0]});
      check("memc_i", memc_i, lv[30:18]);
      rd(8'h00, {20'h0_0000, lv[11:0]});
      rd(8'h20, {13'h0000, lv[30:12]});
      for (i = 1; i < 11; i = i + 1) begin
         if (i != 8) rd({i[5:0], 2'b00}, 32'h0000_0000);
      end
      rd(8'h2C, 32'h0000_0000, `GPP_RESP_SLVERR);
      rd(8'h02, 32'h0000_0000, `GPP_RESP_SLVERR);
      wr(8'h30, 32'hFFFF_FFFF, `GPP_RESP_SLVERR);
      wr(8'h0C, 32'hFFFF_FFFF);
      rd(8'h0C, 32'h0000_0000);
      done("reset and decode");
      // Random strobes: unstrobed bytes must not move
      exp_out = 24'h00_0000;
      for (i = 0; i < 8; i = i + 1) begin
         r = $random(seed);
         m = {{8{r[30]}}, {8{r[29]}}, {8{r[28]}}};
         wr(i[0] ? 8'h08 : 8'h04, r, `GPP_RESP_OKAY, r[31:28]);
         exp_out = i[0] ? exp_out & ~(r[23:0] & m) : exp_out | (r[23:0] & m);
         @(posedge clock);
         check("out_pin", out_pin, exp_out);
      end
      rd(8'h0C, {8'h00, exp_out});
      done("set and clear");
      r = $random(seed);
      periph <= r[23:0];
      wr(8'h24, 32'h00FF_FF00);
      @(posedge clock);
      check("out_pin", out_pin, (r[23:0] & 24'hFF_FF00) | (exp_out & 24'h00_00FF));
      rd(8'h24, 32'h00FF_FF00);
      // Only the middle lane is strobed: the other lanes keep their bits
      wr(8'h24, 32'h0000_00FF, `GPP_RESP_OKAY, 4'h2);
      rd(8'h24, 32'h00FF_0000);
      check("out_pin", out_pin, (r[23:0] & 24'hFF_0000) | (exp_out & 24'h00_FFFF));
      done("peripheral select");
      wr(8'h10, 32'h0000_003F);
      wr(8'h14, 32'h0000_0015);
      repeat (4) @(posedge clock);
      check("io_oe_n", io_oe_n, 6'h00);
      check("io_o", io_o, 6'h15);
      rd(8'h20, {13'h0000, lv[30:18], 6'h15});
      wr(8'h10, 32'h0000_0000);
      repeat (4) @(posedge clock);
      check("io_oe_n", io_oe_n, 6'h3F);
      rd(8'h1C, 32'h0000_0015);
      wr(8'h18, 32'h0000_0004);
      rd(8'h1C, 32'h0000_0011);
      rd(8'h20, {13'h0000, lv[30:12]});
      done("direction");
      @(posedge clock);
      half <= 1'b1;
      rd(8'h28, 32'h0000_0001);
      wr(8'h10, 32'h0007_FFC0);
      wr(8'h14, 32'h0005_5540);
      repeat (4) @(posedge clock);
      check("mem_oe_n", mem_oe_n, 13'h0000);
      check("mem_o", mem_o, 13'h1555);
      check("irq", irq[30:18], 13'h1555);
      check("memc_i", memc_i, 13'h1555);
      r = $random(seed);
      memc_o <= r[12:0];
      memc_oe_n <= r[25:13];
      half <= 1'b0;
      repeat (5) @(posedge clock);
      check("mem_o", mem_o, r[12:0]);
      check("mem_oe_n", mem_oe_n, r[25:13]);
      check("irq", irq[30:18], 13'h0000);
      done("half width");
      report_and_stop;
   end
   // Tests need well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clock);
      failures = failures + 1;
      report_and_stop;
   end
endmodule // tb_gpp_port
